// ===== include/rcd_consts.svh
`ifndef RCD_CONSTS_SVH
`define RCD_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RCD_OFS_RC_CTRL      8'h17
`define RCD_OFS_RC_RATIO     8'h18
`define RCD_OFS_HD_TIMING    8'h19
`define RCD_OFS_HD_THRESH    8'h1A
// ----------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------
`define RCD_RST_RC_CTRL      8'h00
`define RCD_RST_RC_RATIO     8'h00
`define RCD_RST_HD_TIMING    8'h00
`define RCD_RST_HD_THRESH    8'h00
`define RCD_WM_RC_CTRL       8'hC0
`define RCD_WM_RC_RATIO      8'hFF
`define RCD_WM_HD_TIMING     8'hE6
`define RCD_WM_HD_THRESH     8'h7E
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RCD_B_RC_ENABLE      7
`define RCD_B_AUTODET_DIS    6
`define RCD_B_MAIN_MANUAL    7
`define RCD_B_MAIN_SOURCE    6
`define RCD_F_RATIO_M        5:3
`define RCD_F_RATIO_N        2:0
`define RCD_F_MON_RATE       7:6
`define RCD_B_PULSE_WIDTH    5
`define RCD_F_HP_CLK         2:1
`define RCD_B_HOOK_CHOICE    6
`define RCD_F_INSERT_IMP     5:4
`define RCD_B_COUPLING       3
`define RCD_B_DOUBLE_CUR     2
`define RCD_B_DET_ENABLE     1
// ----------------------------------------------------------------
// Timing: clock period and the documented times
// ----------------------------------------------------------------
`define RCD_CLK_NS           8
`define RCD_MON0_US          2000000
`define RCD_MON1_US          1000000
`define RCD_MON2_US          133333
`define RCD_MON3_US          66666
`define RCD_PW0_MS           4
`define RCD_PW1_MS           32
`define RCD_HPC0_MS          1
`define RCD_HPC1_MS          2
`define RCD_HPC2_MS          4
`define RCD_US2CYC(t)        (((t) * 1000) / `RCD_CLK_NS)
`define RCD_MS2CYC(t)        (((t) * 1000000) / `RCD_CLK_NS)
// ----------------------------------------------------------------
// Hook and microphone thresholds in ohm
// ----------------------------------------------------------------
`define RCD_OHM_MIC_LO       11'h320
`define RCD_OHM_HOOK_LO_AC   11'h140
`define RCD_OHM_HOOK_LO_DC   11'h096
`define RCD_OHM_HOOK_HI      11'h2A8
`define RCD_OHM_MIC_HI_AC    11'h546
`define RCD_OHM_MIC_HI_DC    11'h6D6
`endif

// ===== include/rcd_pkg.sv
`default_nettype none
package rcd_pkg;
  // Register byte
  typedef logic [7:0]  rcd_byte_t;
  // Ratio field code
  typedef logic [2:0]  rcd_ratio_t;
  // Resistance in ohm
  typedef logic [10:0] rcd_ohm_t;
  // Monitor rate selection
  typedef enum logic [1:0] {
    RCD_MON_0P5HZ = 2'b00,
    RCD_MON_1HZ   = 2'b01,
    RCD_MON_7P5HZ = 2'b10,
    RCD_MON_15HZ  = 2'b11
  } rcd_mon_e;
  // Headphone detection clock period selection
  typedef enum logic [1:0] {
    RCD_HPC_1MS  = 2'b00,
    RCD_HPC_2MS  = 2'b01,
    RCD_HPC_4MS  = 2'b10,
    RCD_HPC_RSVD = 2'b11
  } rcd_hpc_e;
endpackage : rcd_pkg
`default_nettype wire

// ===== logic/rcd_cfg_bank.sv
// Notes on behaviour
// R1: 0x17 resets zero; bit 7 enables converter
// R2: 0x17 bit 6 set disables rate autodetect
// R3: 0x17 bits 5-0 reserved, host writes zero
// R4: 0x18 bit 7 picks auto or manual rate
// R5: 0x18 bit 6 picks primary or secondary port
// R6: 0x18 bits 5-3 numerator m, 5/7 reserved
// R7: 0x18 bits 2-0 denominator n, 5/7 reserved
// R8: 0x19 bits 7-6 pick monitor rate
// R9: 0x19 bit 5 picks 4 or 32 ms pulse
// R10: 0x19 bits 2-1 pick 1/2/4 ms clock
// R11: 0x1A bit 6 picks low-mic or high-hook thresholds
// R12: coupling bit set changes threshold pairs
// R13: 0x1A bit 1 turns headset detection on
// R14: 0x1A bit 3 selects AC or DC coupling
// R15: host avoids writing reserved field codes
`timescale 1ns/1ns
`default_nettype none
`include "rcd_consts.svh"
module rcd_cfg_bank #(
  parameter int unsigned MON_CYC_0 = `RCD_US2CYC(`RCD_MON0_US),
  parameter int unsigned MON_CYC_1 = `RCD_US2CYC(`RCD_MON1_US),
  parameter int unsigned MON_CYC_2 = `RCD_US2CYC(`RCD_MON2_US),
  parameter int unsigned MON_CYC_3 = `RCD_US2CYC(`RCD_MON3_US),
  parameter int unsigned PW_CYC_0  = `RCD_MS2CYC(`RCD_PW0_MS),
  parameter int unsigned PW_CYC_1  = `RCD_MS2CYC(`RCD_PW1_MS),
  parameter int unsigned HPC_CYC_0 = `RCD_MS2CYC(`RCD_HPC0_MS),
  parameter int unsigned HPC_CYC_1 = `RCD_MS2CYC(`RCD_HPC1_MS),
  parameter int unsigned HPC_CYC_2 = `RCD_MS2CYC(`RCD_HPC2_MS)
) (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  // Register access from the control interface
  input  wire logic        REG_WR_EN,
  input  wire logic        REG_RD_EN,
  input  wire logic [7:0]  REG_ADDR,
  input  wire rcd_pkg::rcd_byte_t REG_WDATA,
  output var  rcd_pkg::rcd_byte_t REG_RDATA,
  // Rate converter controls
  output var  logic        RATE_CONVERTER_ENABLE,
  output var  logic        RATE_AUTODETECT_DISABLE,
  output var  logic        MAIN_RATE_MANUAL,
  output var  logic        MAIN_RATE_SOURCE,
  output var  rcd_pkg::rcd_ratio_t RATIO_M_VALUE,
  output var  logic        RATIO_M_INFER,
  output var  rcd_pkg::rcd_ratio_t RATIO_N_VALUE,
  output var  logic        RATIO_N_INFER,
  output var  logic        RESERVED_CODE_SEEN,
  // Headset detection controls
  output var  logic        HEADSET_DETECT_ENABLE,
  output var  logic        HEADPHONE_DC_COUPLED,
  output var  logic        DOUBLE_DETECT_CURRENT,
  output var  logic [1:0]  HOOK_INSERT_IMPEDANCE_CHOICE,
  output var  rcd_pkg::rcd_ohm_t HOOK_LIMIT_OHM,
  output var  rcd_pkg::rcd_ohm_t MIC_MIN_OHM,
  // Detection timing strobes
  output var  logic        MONITOR_TICK,
  output var  logic        DETECT_PULSE,
  output var  logic        HPDET_CLK_TICK
);
  import rcd_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  rcd_byte_t   ctrl_r;       // Converter control
  rcd_byte_t   ratio_r;      // Main rate and ratio selection
  rcd_byte_t   timing_r;     // Detection timing
  rcd_byte_t   thresh_r;     // Thresholds and detect enable
  logic        wr_ctrl;      // Write strobe decodes
  logic        wr_ratio;
  logic        wr_timing;
  logic        wr_thresh;

  assign wr_ctrl   = REG_WR_EN && (REG_ADDR == `RCD_OFS_RC_CTRL);
  assign wr_ratio  = REG_WR_EN && (REG_ADDR == `RCD_OFS_RC_RATIO);
  assign wr_timing = REG_WR_EN && (REG_ADDR == `RCD_OFS_HD_TIMING);
  assign wr_thresh = REG_WR_EN && (REG_ADDR == `RCD_OFS_HD_THRESH);

  // Writes; reserved bits are masked so they always hold zero
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl_r   <= `RCD_RST_RC_CTRL;     // R1
      ratio_r  <= `RCD_RST_RC_RATIO;
      timing_r <= `RCD_RST_HD_TIMING;
      thresh_r <= `RCD_RST_HD_THRESH;
    end
    else
    begin
      // A host that writes ones to reserved bits is forgiven here
      if (wr_ctrl)
        ctrl_r <= REG_WDATA & `RCD_WM_RC_CTRL;     // R3
      if (wr_ratio)
        ratio_r <= REG_WDATA & `RCD_WM_RC_RATIO;
      if (wr_timing)
        timing_r <= REG_WDATA & `RCD_WM_HD_TIMING;
      if (wr_thresh)
        thresh_r <= REG_WDATA & `RCD_WM_HD_THRESH;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      REG_RDATA <= 8'h00;
    else if (REG_RD_EN)
    begin
      unique case (REG_ADDR)
        `RCD_OFS_RC_CTRL:   REG_RDATA <= ctrl_r;
        `RCD_OFS_RC_RATIO:  REG_RDATA <= ratio_r;
        `RCD_OFS_HD_TIMING: REG_RDATA <= timing_r;
        `RCD_OFS_HD_THRESH: REG_RDATA <= thresh_r;
        default:            REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Plain control bits, straight from register flops
  // ----------------------------------------------------------------
  assign RATE_CONVERTER_ENABLE   = ctrl_r[`RCD_B_RC_ENABLE];     // R1
  assign RATE_AUTODETECT_DISABLE = ctrl_r[`RCD_B_AUTODET_DIS];   // R2
  assign MAIN_RATE_MANUAL        = ratio_r[`RCD_B_MAIN_MANUAL];  // R4
  assign MAIN_RATE_SOURCE        = ratio_r[`RCD_B_MAIN_SOURCE];  // R5
  assign HEADSET_DETECT_ENABLE   = thresh_r[`RCD_B_DET_ENABLE];  // R13
  assign HEADPHONE_DC_COUPLED    = thresh_r[`RCD_B_COUPLING];    // R14
  assign DOUBLE_DETECT_CURRENT   = thresh_r[`RCD_B_DOUBLE_CUR];
  assign HOOK_INSERT_IMPEDANCE_CHOICE = thresh_r[`RCD_F_INSERT_IMP];

  // ----------------------------------------------------------------
  // Decoded fields, registered one cycle behind the storage
  // ----------------------------------------------------------------
  rcd_ratio_t  m_code;       // Numerator code
  rcd_ratio_t  n_code;       // Denominator code
  logic        m_rsvd;       // Numerator code 5 or 7
  logic        n_rsvd;       // Denominator code 5 or 7
  logic        hpc_rsvd;     // Clock period code 3

  assign m_code   = ratio_r[`RCD_F_RATIO_M];
  assign n_code   = ratio_r[`RCD_F_RATIO_N];
  assign m_rsvd   = (m_code == 3'h5) || (m_code == 3'h7);   // R6
  assign n_rsvd   = (n_code == 3'h5) || (n_code == 3'h7);   // R7
  assign hpc_rsvd = (timing_r[`RCD_F_HP_CLK] == RCD_HPC_RSVD);

  // Ratio decode; a reserved code is passed on as "infer" with value 0
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      RATIO_M_VALUE      <= 3'h0;
      RATIO_M_INFER      <= 1'b1;
      RATIO_N_VALUE      <= 3'h0;
      RATIO_N_INFER      <= 1'b1;
      RESERVED_CODE_SEEN <= 1'b0;
    end
    else
    begin
      RATIO_M_VALUE      <= m_rsvd ? 3'h0 : m_code;            // R6
      RATIO_M_INFER      <= (m_code == 3'h0) || m_rsvd;        // R6
      RATIO_N_VALUE      <= n_rsvd ? 3'h0 : n_code;            // R7
      RATIO_N_INFER      <= (n_code == 3'h0) || n_rsvd;        // R7
      RESERVED_CODE_SEEN <= m_rsvd || n_rsvd || hpc_rsvd;
    end
  end

  // Threshold pair from hook choice and coupling
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      HOOK_LIMIT_OHM <= `RCD_OHM_HOOK_LO_AC;
      MIC_MIN_OHM    <= `RCD_OHM_MIC_LO;
    end
    else if (!thresh_r[`RCD_B_HOOK_CHOICE])
    begin
      // Favour low microphone resistance
      MIC_MIN_OHM    <= `RCD_OHM_MIC_LO;                       // R11
      HOOK_LIMIT_OHM <= thresh_r[`RCD_B_COUPLING] ?
                        `RCD_OHM_HOOK_LO_DC : `RCD_OHM_HOOK_LO_AC; // R12
    end
    else
    begin
      // Favour high hook button resistance
      HOOK_LIMIT_OHM <= `RCD_OHM_HOOK_HI;                      // R11
      MIC_MIN_OHM    <= thresh_r[`RCD_B_COUPLING] ?
                        `RCD_OHM_MIC_HI_DC : `RCD_OHM_MIC_HI_AC;   // R12
    end
  end

  // ----------------------------------------------------------------
  // Detection timing dividers
  // ----------------------------------------------------------------
  logic        det_en;       // Detection enabled
  logic [31:0] mon_lim;      // Monitor period in cycles
  logic [31:0] pw_lim;       // Pulse high width in cycles
  logic [31:0] hpc_lim;      // Detect clock period in cycles
  logic [31:0] mon_cnt_r;    // Monitor period counter
  logic [31:0] pw_cnt_r;     // Pulse width counter
  logic [31:0] hpc_cnt_r;    // Detect clock counter
  logic        mon_wrap;     // Monitor period ends this cycle
  logic        hpc_wrap;     // Detect clock period ends this cycle

  assign det_en = thresh_r[`RCD_B_DET_ENABLE];

  // Period lookups from the timing register
  always_comb
  begin
    unique case (rcd_mon_e'(timing_r[`RCD_F_MON_RATE]))              // R8
      RCD_MON_0P5HZ: mon_lim = MON_CYC_0;
      RCD_MON_1HZ:   mon_lim = MON_CYC_1;
      RCD_MON_7P5HZ: mon_lim = MON_CYC_2;
      RCD_MON_15HZ:  mon_lim = MON_CYC_3;
    endcase
    pw_lim = timing_r[`RCD_B_PULSE_WIDTH] ? PW_CYC_1 : PW_CYC_0;    // R9
    unique case (rcd_hpc_e'(timing_r[`RCD_F_HP_CLK]))               // R10
      RCD_HPC_1MS:  hpc_lim = HPC_CYC_0;
      RCD_HPC_2MS:  hpc_lim = HPC_CYC_1;
      RCD_HPC_4MS:  hpc_lim = HPC_CYC_2;
      RCD_HPC_RSVD: hpc_lim = 32'h0;
    endcase
  end

  // A shortened period after a write wraps at once rather than overrun
  assign mon_wrap = det_en && (mon_cnt_r >= mon_lim - 32'h1);
  assign hpc_wrap = det_en && !hpc_rsvd && (hpc_cnt_r >= hpc_lim - 32'h1);

  // Monitor rate divider
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      mon_cnt_r    <= 32'h0;
      MONITOR_TICK <= 1'b0;
    end
    else
    begin
      mon_cnt_r    <= (mon_wrap || !det_en) ? 32'h0 : mon_cnt_r + 32'h1;
      MONITOR_TICK <= mon_wrap;                                     // R8
    end
  end

  // Detector pulse, high for the selected width starting with each tick
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      pw_cnt_r     <= 32'h0;
      DETECT_PULSE <= 1'b0;
    end
    else if (!det_en)
    begin
      pw_cnt_r     <= 32'h0;                                        // R13
      DETECT_PULSE <= 1'b0;
    end
    else if (mon_wrap)
    begin
      pw_cnt_r     <= pw_lim - 32'h1;                               // R9
      DETECT_PULSE <= 1'b1;
    end
    else if (pw_cnt_r != 32'h0)
      pw_cnt_r     <= pw_cnt_r - 32'h1;
    else
      DETECT_PULSE <= 1'b0;
  end

  // Headphone detection clock; a reserved code stops it
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      hpc_cnt_r      <= 32'h0;
      HPDET_CLK_TICK <= 1'b0;
    end
    else
    begin
      hpc_cnt_r      <= (hpc_wrap || !det_en || hpc_rsvd) ? 32'h0 :
                        hpc_cnt_r + 32'h1;
      HPDET_CLK_TICK <= hpc_wrap;                                   // R10
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_enable_write: assert property (@(posedge SYS_CLK) disable iff (RESET) // R1
    wr_ctrl |=> RATE_CONVERTER_ENABLE == $past(REG_WDATA[7]))
    else $error("converter enable did not follow write");
  a_autodet_write: assert property (@(posedge SYS_CLK) // R2
    disable iff (RESET)
    wr_ctrl |=> RATE_AUTODETECT_DISABLE == $past(REG_WDATA[6]))
    else $error("autodetect disable did not follow write");
  a_rsvd_reads_zero: assert property (@(posedge SYS_CLK) // R3
    disable iff (RESET)
    REG_RD_EN && REG_ADDR == `RCD_OFS_RC_CTRL |=> REG_RDATA[5:0] == 6'h0)
    else $error("reserved control bits read nonzero");
  a_main_rate_sel: assert property (@(posedge SYS_CLK) // R5
    disable iff (RESET)
    wr_ratio |=> MAIN_RATE_MANUAL == $past(REG_WDATA[7]) &&
                 MAIN_RATE_SOURCE == $past(REG_WDATA[6]))
    else $error("main rate selection did not follow write");
  a_ratio_m_decode: assert property (@(posedge SYS_CLK) // R6
    disable iff (RESET)
    wr_ratio |-> ##2 RATIO_M_INFER == ($past(REG_WDATA[5:3], 2) == 3'h0 ||
      $past(REG_WDATA[5:3], 2) == 3'h5 || $past(REG_WDATA[5:3], 2) == 3'h7))
    else $error("numerator infer flag wrong");
  a_ratio_n_value: assert property (@(posedge SYS_CLK) // R7
    disable iff (RESET)
    wr_ratio && REG_WDATA[2:0] == 3'h6 |-> ##2 RATIO_N_VALUE == 3'h6 &&
      !RATIO_N_INFER)
    else $error("denominator value wrong");
  a_mon_bound: assert property (@(posedge SYS_CLK) disable iff (RESET) // R8
    MONITOR_TICK |-> $past(mon_cnt_r) >= $past(mon_lim) - 32'h1)
    else $error("monitor tick before its period");
  a_pulse_width: assert property (@(posedge SYS_CLK) disable iff (RESET) // R9
    $rose(DETECT_PULSE) |-> pw_cnt_r == $past(pw_lim) - 32'h1)
    else $error("detector pulse width wrong");
  a_hpclk_rsvd: assert property (@(posedge SYS_CLK) disable iff (RESET) // R10
    hpc_rsvd |=> !HPDET_CLK_TICK)
    else $error("detect clock ran on reserved code");
  a_hook_thresh: assert property (@(posedge SYS_CLK) disable iff (RESET) // R12
    wr_thresh && REG_WDATA[6] && REG_WDATA[3] |-> ##2
      MIC_MIN_OHM == `RCD_OHM_MIC_HI_DC && HOOK_LIMIT_OHM == `RCD_OHM_HOOK_HI)
    else $error("DC threshold pair wrong");
  a_detect_off: assert property (@(posedge SYS_CLK) disable iff (RESET) // R13
    !det_en |=> !DETECT_PULSE && !HPDET_CLK_TICK && !MONITOR_TICK)
    else $error("detection strobes while disabled");
  a_coupling_write: assert property (@(posedge SYS_CLK) // R14
    disable iff (RESET)
    wr_thresh |=> HEADPHONE_DC_COUPLED == $past(REG_WDATA[3]))
    else $error("coupling bit did not follow write");
endmodule : rcd_cfg_bank
`default_nettype wire

// ===== testbench/tb_rate_converter_headset_detect_cfg.sv
`timescale 1ns/1ns
`default_nettype none
`include "rcd_consts.svh"
module tb_rate_converter_headset_detect_cfg;
  import rcd_pkg::*;
  // ----------------------------------------------------------------
  // Shortened timing counts, so one detect period is a few cycles
  // ----------------------------------------------------------------
  localparam int unsigned MON [4] = '{40, 20, 8, 6};
  localparam int unsigned PW  [2] = '{3, 5};
  localparam int unsigned HPC [3] = '{4, 6, 10};
  logic       sys_clk, reset, wr_en, rd_en;   // Clock, reset, strobes
  logic [7:0] addr;                           // Register address
  rcd_byte_t  wdata, rdata;                   // Bus data
  logic       conv_en, auto_dis, manual, source, m_inf, n_inf, rsv_seen;
  rcd_ratio_t m_val, n_val;                   // Decoded ratio
  logic       det_en, dc_cpl, dbl_cur, mon_tick, det_pulse, hp_tick;
  logic [1:0] ins_imp;                        // Insert impedance choice
  rcd_ohm_t   hook_ohm, mic_ohm;              // Thresholds
  int         n_fail, n_compared, cyc;        // Report counters
  wire logic [2:0] tick_v = {hp_tick, det_pulse, mon_tick};
  rcd_cfg_bank #(
    .MON_CYC_0(MON[0]), .MON_CYC_1(MON[1]), .MON_CYC_2(MON[2]),
    .MON_CYC_3(MON[3]), .PW_CYC_0(PW[0]), .PW_CYC_1(PW[1]),
    .HPC_CYC_0(HPC[0]), .HPC_CYC_1(HPC[1]), .HPC_CYC_2(HPC[2])
  ) i_dut (
    .SYS_CLK(sys_clk), .RESET(reset), .REG_WR_EN(wr_en),
    .REG_RD_EN(rd_en), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .RATE_CONVERTER_ENABLE(conv_en),
    .RATE_AUTODETECT_DISABLE(auto_dis), .MAIN_RATE_MANUAL(manual),
    .MAIN_RATE_SOURCE(source), .RATIO_M_VALUE(m_val),
    .RATIO_M_INFER(m_inf), .RATIO_N_VALUE(n_val), .RATIO_N_INFER(n_inf),
    .RESERVED_CODE_SEEN(rsv_seen), .HEADSET_DETECT_ENABLE(det_en),
    .HEADPHONE_DC_COUPLED(dc_cpl), .DOUBLE_DETECT_CURRENT(dbl_cur),
    .HOOK_INSERT_IMPEDANCE_CHOICE(ins_imp), .HOOK_LIMIT_OHM(hook_ohm),
    .MIC_MIN_OHM(mic_ohm), .MONITOR_TICK(mon_tick),
    .DETECT_PULSE(det_pulse), .HPDET_CLK_TICK(hp_tick)
  );
  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;
  // Watchdog: whole run needs a few thousand cycles at most
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // Write strobe for one edge; a spare cycle lets decoded outputs land
  task automatic wr(input logic [7:0] a, input rcd_byte_t d);
    @(negedge sys_clk);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge sys_clk);
    wr_en = 1'b0;
    @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input rcd_byte_t exp);
    @(negedge sys_clk);
    rd_en = 1'b1;
    addr  = a;
    @(negedge sys_clk);
    rd_en = 1'b0;
    chk($sformatf("read %0h", a), {8'h00, exp}, {8'h00, rdata});
  endtask : rd
  // Cycles from the current strobe (or next one) to the following one
  task automatic gap(input int k, output int p);
    p = 0;
    while (tick_v[k] !== 1'b1 && p < 400)
    begin
      @(negedge sys_clk);
      p = p + 1;
    end
    p = 0;
    do
    begin
      @(negedge sys_clk);
      p = p + 1;
    end
    while (tick_v[k] !== 1'b1 && p < 400);
  endtask : gap
  task automatic hi_len(input int k, output int w);
    w = 0;
    while (tick_v[k] === 1'b1 && w < 400)
    begin
      @(negedge sys_clk);
      w = w + 1;
    end
  endtask : hi_len
  task automatic count(input int k, input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(negedge sys_clk);
      if (tick_v[k] === 1'b1)
        c = c + 1;
    end
  endtask : count
  function automatic logic lit(input logic [2:0] c);
    return c inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  endfunction : lit
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [2:0] m3, n3;
    logic [1:0] c2;
    rcd_byte_t  b;
    int         i, p;
    {reset, wr_en, rd_en, addr, wdata} = {2'b10, 1'b0, 8'h00, 8'h00};
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    // Reset contents and decoded defaults
    for (i = 8'h17; i <= 8'h1A; i++) rd(8'(i), 8'h00);
    chk("m infer", 16'h0001, {15'h0000, m_inf});
    chk("n infer", 16'h0001, {15'h0000, n_inf});
    chk("hook", 16'(`RCD_OHM_HOOK_LO_AC), 16'(hook_ohm));
    chk("mic", 16'(`RCD_OHM_MIC_LO), 16'(mic_ohm));
    rd(8'h1B, 8'h00);
    // Converter control: reserved bits drop, two live bits
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'hC0);
    chk("enable", 16'h0001, {15'h0000, conv_en});
    wr(8'h17, 8'h40);
    chk("enable", 16'h0000, {15'h0000, conv_en});
    chk("autodet", 16'h0001, {15'h0000, auto_dis});
    // Main rate manual selection and source
    for (i = 0; i < 4; i++)
    begin
      c2 = 2'(i);
      wr(8'h18, {c2, 6'h00});
      chk("manual", {15'h0000, c2[1]}, {15'h0000, manual});
      chk("source", {15'h0000, c2[0]}, {15'h0000, source});
    end
    // Every m and n code, paired so reserved codes meet normal ones
    for (i = 0; i < 8; i++)
    begin
      m3 = 3'(i);
      n3 = 3'(7 - i);
      wr(8'h18, {2'b00, m3, n3});
      rd(8'h18, {2'b00, m3, n3});
      chk("m val", 16'(lit(m3) ? m3 : 3'h0), 16'(m_val));
      chk("m inf", {15'h0000, !lit(m3)}, {15'h0000, m_inf});
      chk("n val", 16'(lit(n3) ? n3 : 3'h0), 16'(n_val));
      chk("n inf", {15'h0000, !lit(n3)}, {15'h0000, n_inf});
      chk("rsv", {15'h0000, m3 inside {3'h5, 3'h7} ||
          n3 inside {3'h5, 3'h7}}, {15'h0000, rsv_seen});
    end
    wr(8'h18, 8'h00);
    // Detect timing: rate, pulse width and clock period per code
    for (i = 0; i < 4; i++)
    begin
      c2 = 2'(i);
      b = {c2, c2[0], 2'b00, c2, 1'b0};
      wr(8'h1A, 8'h00);
      wr(8'h19, b | 8'h19);
      rd(8'h19, b);
      wr(8'h1A, 8'h02);
      gap(0, p);
      gap(0, p);
      chk("monitor", 16'(MON[i]), 16'(p));
      hi_len(1, p);
      chk("pulse", 16'(PW[c2[0]]), 16'(p));
      if (i < 3)
      begin
        gap(2, p);
        gap(2, p);
        chk("hp clock", 16'(HPC[i]), 16'(p));
      end
      else
      begin
        count(2, 40, p);
        chk("hp stopped", 16'h0000, 16'(p));
        chk("rsv clk", 16'h0001, {15'h0000, rsv_seen});
      end
    end
    // Threshold pairs for each choice and coupling
    for (i = 0; i < 4; i++)
    begin
      c2 = 2'(i);
      b = {1'b0, c2[1], c2, c2[0], c2[0], 2'b10};
      wr(8'h1A, b | 8'h81);
      rd(8'h1A, b);
      chk("dc", {15'h0000, c2[0]}, {15'h0000, dc_cpl});
      chk("dbl", {15'h0000, c2[0]}, {15'h0000, dbl_cur});
      chk("imp", {14'h0000, c2}, {14'h0000, ins_imp});
      chk("det en", 16'h0001, {15'h0000, det_en});
      chk("hook", 16'(c2[1] ? `RCD_OHM_HOOK_HI : c2[0] ?
          `RCD_OHM_HOOK_LO_DC : `RCD_OHM_HOOK_LO_AC),
          16'(hook_ohm));
      chk("mic", 16'(!c2[1] ? `RCD_OHM_MIC_LO : c2[0] ?
          `RCD_OHM_MIC_HI_DC : `RCD_OHM_MIC_HI_AC),
          16'(mic_ohm));
    end
    // Mid-run reset clears loaded registers and decoded outputs
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    rd(8'h17, 8'h00);
    chk("autodet", 16'h0000, {15'h0000, auto_dis});
    chk("hook", 16'(`RCD_OHM_HOOK_LO_AC), 16'(hook_ohm));
    // Detection off: no monitor strobes at all
    wr(8'h19, 8'hC0);
    wr(8'h1A, 8'h00);
    count(0, 60, p);
    chk("no tick", 16'h0000, 16'(p));
    chk("det en", 16'h0000, {15'h0000, det_en});
    print_verdict();
  end
endmodule : tb_rate_converter_headset_detect_cfg
`default_nettype wire
